/* File: bench/ptcg_front_end.sv */
// front-end model: delivers measurement samples and gates the pack switches
`timescale 1ns/1ps
module ptcg_front_end (
  input wire logic clk,
  input wire logic charge_switch,
  input wire logic discharge_switch,
  input wire logic shutdown_req,
  output logic meas_valid,
  output logic [15:0] temp_raw,
  output logic [15:0] current_raw,
  output logic [15:0] voltage_raw,
  output logic [15:0] coulomb_raw,
  output logic charge_switch_on,
  output logic dsg_fet_on
);
  initial begin
    meas_valid = 1'b0;
    temp_raw = 16'h0000;
    current_raw = 16'h0000;
    voltage_raw = 16'h0000;
    coulomb_raw = 16'h0000;
  end
  // the front end drops every switch once shutdown is requested
  assign charge_switch_on = charge_switch & ~shutdown_req;
  assign dsg_fet_on = discharge_switch & ~shutdown_req;
  task automatic sample(input logic [15:0] t, input logic [15:0] c, input logic [15:0] v, input logic [15:0] q);
    @(posedge clk);
    meas_valid <= 1'b1;
    temp_raw <= t;
    current_raw <= c;
    voltage_raw <= v;
    coulomb_raw <= q;
    @(posedge clk);
    meas_valid <= 1'b0;
    // data means nothing outside the strobe, so it is scrambled to catch late capture
    temp_raw <= ~t;
    current_raw <= ~c;
    voltage_raw <= ~v;
    coulomb_raw <= ~q;
  endtask
endmodule

/* File: bench/testbench.sv */
// self-checking bench for the pack thermal/current guard
`timescale 1ns/1ps
module testbench;
  import ptcg_pkg::*;
  typedef struct packed {logic [56:0] v; logic [56:0] m;} ptcg_note_t;
  localparam logic [15:0] V_OK = 16'h0e10;
  localparam logic [15:0] T_OK = 16'h0104;
  logic clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, meas_valid, pend;
  logic [ADDR_W-1:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [DATA_W-1:0] wb_dat_i, wb_dat_o;
  logic [15:0] temp_raw, current_raw, voltage_raw, coulomb_raw, temp_calibrated, current_filtered, coulomb_calibrated;
  logic pack_present_pin, adapter_present_pin, cell_undervoltage_flag, charge_switch_on, dsg_fet_on;
  logic charge_switch, discharge_switch, pack_manager_status, charge_request_zero, end_discharge_alarm;
  logic temp_failure, perm_failure, switch_failure, shutdown_req;
  logic [56:0] obs;
  logic [15:0] cfg [NSLOT];
  logic [15:0] cur_tab [7];
  logic [15:0] st_tab [7];
  ptcg_note_t ms_q[$], rd_q[$], mon_n;
  int n_mismatch, samples_checked, k;
  assign obs = {charge_switch, discharge_switch, pack_manager_status, charge_request_zero, end_discharge_alarm,
    temp_failure, perm_failure, switch_failure, shutdown_req, temp_calibrated, current_filtered, coulomb_calibrated};
  ptcg_guard #(.TICKS_PER_SEC(20)) uut (.clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .meas_valid(meas_valid), .temp_raw(temp_raw), .current_raw(current_raw),
    .voltage_raw(voltage_raw), .coulomb_raw(coulomb_raw), .pack_present_pin(pack_present_pin),
    .adapter_present_pin(adapter_present_pin), .cell_undervoltage_flag(cell_undervoltage_flag),
    .charge_switch(charge_switch), .discharge_switch(discharge_switch), .pack_manager_status(pack_manager_status),
    .charge_request_zero(charge_request_zero), .end_discharge_alarm(end_discharge_alarm),
    .temp_failure(temp_failure), .perm_failure(perm_failure), .switch_failure(switch_failure),
    .shutdown_req(shutdown_req), .temp_calibrated(temp_calibrated), .current_filtered(current_filtered),
    .coulomb_calibrated(coulomb_calibrated));
  ptcg_front_end fe (.clk(clk), .charge_switch(charge_switch), .discharge_switch(discharge_switch),
    .shutdown_req(shutdown_req), .meas_valid(meas_valid), .temp_raw(temp_raw), .current_raw(current_raw),
    .voltage_raw(voltage_raw), .coulomb_raw(coulomb_raw), .charge_switch_on(charge_switch_on), .dsg_fet_on(dsg_fet_on));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input logic [56:0] seen, input logic [56:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    if (ms_q.size() + rd_q.size() != 0) n_mismatch++;
    $display("mismatches %0d, comparisons %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic bus(input logic we, input logic [8:0] idx, input logic [15:0] d);
    bit got;
    got = 1'b0;
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {1'b0, idx, 2'b00};
    wb_sel_i <= 4'h3;
    wb_dat_i <= {16'h0000, d};
    for (int i = 0; i < 20 && !got; i++) begin
      @(posedge clk);
      got = (wb_ack_o === 1'b1);
    end
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (!got) begin
      n_mismatch++;
      report_and_stop();
    end
  endtask
  task automatic rd(input logic [8:0] idx, input logic [15:0] exp, input logic [15:0] msk);
    rd_q.push_back('{v: {41'h0, exp & msk}, m: {25'h0, 16'hffff, msk}});
    bus(1'b0, idx, 16'h0000);
  endtask
  function automatic logic [15:0] filt(input logic [15:0] c);
    if ($signed(c) < $signed(cfg[S_BAND]) && $signed(c) > -$signed(cfg[S_BAND])) return 16'h0000;
    return c;
  endfunction
  task automatic send(input logic [15:0] t, input logic [15:0] c, input logic [15:0] v, input logic [8:0] fl,
    input logic [8:0] fm);
    logic [15:0] q;
    q = 16'($urandom);
    ms_q.push_back('{v: {fl & fm, t + {{8{cfg[S_TCAL][7]}}, cfg[S_TCAL][7:0]}, filt(c),
      q + {{8{cfg[S_CCAL][7]}}, cfg[S_CCAL][7:0]}}, m: {fm, 48'hffff_ffff_ffff}});
    fe.sample(t, c, v, q);
  endtask
  task automatic reset_dut();
    rst_n <= 1'b0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk(obs, 57'h0);
  endtask
  task automatic prog();
    for (int s = 0; s < NSLOT; s++) bus(1'b1, SLOT_IDX[s], cfg[s]);
  endtask
  // perm failure is sticky, so each enable is tried once off and once on, then reset
  task automatic fatal_pair(input logic [15:0] en, input logic [15:0] t, input logic [15:0] c);
    send(t, c, V_OK, 9'h000, 9'h004);
    bus(1'b1, IDX_CONTROL, en);
    send(t, c, V_OK, 9'h004, 9'h004);
    reset_dut();
    prog();
  endtask
  always @(posedge clk) begin
    if (pend) begin
      if (ms_q.size() == 0) n_mismatch++;
      else begin
        mon_n = ms_q.pop_front();
        chk(obs & mon_n.m, mon_n.v);
      end
    end
    pend = meas_valid;
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
      if (rd_q.size() == 0) n_mismatch++;
      else begin
        mon_n = rd_q.pop_front();
        chk({25'h0, wb_dat_o} & mon_n.m, mon_n.v);
      end
    end
  end
  initial begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    report_and_stop();
  end
  initial begin
    void'($urandom(32'h70eab81a));
    {rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i, pend} = '0;
    {pack_present_pin, adapter_present_pin, cell_undervoltage_flag} = 3'h6;
    cfg = '{16'h0000, 16'h01c2, 16'h0bb8, 16'h01f4, 16'h01c2, 16'h0258, 16'h0226, 16'h02bc, 16'h02ee, 16'h00ce,
      16'h0032, 16'h09c4, 16'h00f6, 16'h0005, 16'h0064, 16'hff9c, 16'h00c8, 16'hff38, 16'h0002, 16'h0000};
    cur_tab = '{16'h0064, 16'h0063, 16'hff9b, 16'hff9c, 16'h0031, 16'hffcf, 16'h0032};
    st_tab = '{16'h0400, 16'h0000, 16'h0800, 16'h0800, 16'h0000, 16'h0000, 16'h0000};
    reset_dut();
    for (int s = 0; s < NSLOT; s++) begin
      logic [15:0] r;
      r = 16'($urandom);
      rd(SLOT_IDX[s], 16'h0000, 16'hffff);
      bus(1'b1, SLOT_IDX[s], r);
      rd(SLOT_IDX[s], r & SLOT_MASK[s], 16'hffff);
    end
    bus(1'b1, 9'h045, 16'hffff);
    rd(9'h045, 16'h0000, 16'hffff);
    bus(1'b1, IDX_STATUS, 16'hffff);
    rd(IDX_STATUS, 16'h0000, 16'hffff);
    prog();
    send(T_OK, 16'h0000, V_OK, 9'h180, 9'h1ff);
    send(16'hfffb, 16'h0000, V_OK, 9'h0a0, 9'h1ff);
    send(16'hffc4, 16'h0000, V_OK, 9'h068, 9'h168);
    send(T_OK, 16'h0000, V_OK, 9'h180, 9'h1ff);
    send(16'h0294, 16'h0000, V_OK, 9'h068, 9'h1ff);
    send(16'h024e, 16'h0000, V_OK, 9'h068, 9'h1ff);
    send(16'h01fe, 16'h0000, V_OK, 9'h1a0, 9'h1ff);
    send(16'h0212, 16'h01f4, V_OK, 9'h068, 9'h07f);
    rd(IDX_STATUS, 16'h0402, 16'h0402);
    send(16'h01d6, 16'h01f4, V_OK, 9'h068, 9'h068);
    adapter_present_pin <= 1'b0;
    repeat (3) @(posedge clk);
    send(16'h01d6, 16'h01f4, V_OK, 9'h020, 9'h068);
    adapter_present_pin <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      send(T_OK, cur_tab[i], V_OK, 9'h000, 9'h000);
      rd(IDX_STATUS, st_tab[i], 16'h0c00);
    end
    send(T_OK, 16'h0000, 16'h0b54, 9'h010, 9'h010);
    cell_undervoltage_flag <= 1'b1;
    repeat (3) @(posedge clk);
    send(T_OK, 16'h0000, 16'h0c1c, 9'h010, 9'h010);
    cell_undervoltage_flag <= 1'b0;
    repeat (3) @(posedge clk);
    send(T_OK, 16'h0000, 16'h0c1c, 9'h000, 9'h010);
    send(16'h0294, 16'h0000, V_OK, 9'h068, 9'h1ff);
    pack_present_pin <= 1'b0;
    repeat (3) @(posedge clk);
    send(16'h024e, 16'h0000, V_OK, 9'h1a0, 9'h1ff);
    bus(1'b1, IDX_CONTROL, 16'h0001);
    send(16'h0294, 16'h0000, V_OK, 9'h068, 9'h1ff);
    send(16'h024e, 16'h0000, V_OK, 9'h068, 9'h1ff);
    pack_present_pin <= 1'b1;
    fatal_pair(16'h0002, 16'h02da, 16'h01f4);
    fatal_pair(16'h0004, 16'h0320, 16'hfe0c);
    send(16'hfffb, 16'h012c + 16'($urandom % 256), V_OK, 9'h020, 9'h122);
    for (k = 0; k < 200 && switch_failure !== 1'b1; k++) @(posedge clk);
    chk({56'h0, switch_failure}, 57'h1);
    chk(57'(k > 15), 57'h1);
    send(T_OK, 16'h0000, 16'h0960, 9'h001, 9'h181);
    repeat (4) @(posedge clk);
    chk({55'h0, charge_switch_on, dsg_fet_on}, 57'h0);
    report_and_stop();
  end
endmodule

/* File: include/ptcg_pkg.sv */
// package of register map, field layout and timing constants for the pack thermal/current guard
// Functional notes
// R1: cold below suspend limit: temporary fail, charge off
// R2: cold suspend clears on warming or removal
// R3: below cold inhibit: zero charge request, charge off
// R4: above hot inhibit: zero charge request
// R5: hot while charging: temporary fail, present status
// R6: hot suspend clears on recover, adapter or removal
// R7: discharge overheat: both switches off, present status
// R8: overheat clears on recover; removal unless fixed
// R9: charging above fatal limit with enable: permanent
// R10: discharging above fatal limit with enable: permanent
// R11: current at or above charge threshold is charging
// R12: current at or below discharge threshold: discharging
// R13: leak through off switch for time: failed
// R14: end discharge alarm below voltage, hysteresis flag
// R15: add signed offset to each temperature sample
// R16: add signed offset to each coulomb sample
// R17: current inside ignore band reads as zero
// R18: below power off voltage: shut down, switches off
// R19: configuration bit selects fixed battery mode
// R20: all decisions update on each sample's cycle; switch failure (R13) sets on any cycle once the leak time is reached
package ptcg_pkg;
  localparam int CLK_HZ = 200_000_000;
  localparam int SECOND_S = 1;
  localparam int CYCLES_PER_SECOND = CLK_HZ * SECOND_S;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int NSLOT = 20;
  // register indices; byte address is four times the index
  localparam logic [8:0] IDX_CHG_INH_COLD = 9'h046;
  localparam logic [8:0] IDX_CHG_INH_HOT = 9'h047;
  localparam logic [8:0] IDX_END_DSG_V = 9'h067;
  localparam logic [8:0] IDX_CHG_SUS_HOT = 9'h06d;
  localparam logic [8:0] IDX_CHG_SUS_HOT_REC = 9'h06f;
  localparam logic [8:0] IDX_DSG_HOT = 9'h071;
  localparam logic [8:0] IDX_DSG_HOT_REC = 9'h073;
  localparam logic [8:0] IDX_CHG_FATAL_HOT = 9'h075;
  localparam logic [8:0] IDX_DSG_FATAL_HOT = 9'h077;
  localparam logic [8:0] IDX_CHG_SUS_COLD = 9'h079;
  localparam logic [8:0] IDX_IGNORE_BAND = 9'h07b;
  localparam logic [8:0] IDX_POWER_OFF_V = 9'h07c;
  localparam logic [8:0] IDX_TEMP_CAL = 9'h0d6;
  localparam logic [8:0] IDX_COULOMB_CAL = 9'h0d7;
  localparam logic [8:0] IDX_CHG_SENSE = 9'h113;
  localparam logic [8:0] IDX_DSG_SENSE = 9'h115;
  localparam logic [8:0] IDX_LEAK_CHG = 9'h125;
  localparam logic [8:0] IDX_LEAK_DSG = 9'h127;
  localparam logic [8:0] IDX_LEAK_TIME = 9'h129;
  localparam logic [8:0] IDX_CONTROL = 9'h140;
  localparam logic [8:0] IDX_STATUS = 9'h141;
  // slot table: index and implemented bits, slot order fixed below
  localparam logic [8:0] SLOT_IDX [NSLOT] = '{IDX_CHG_INH_COLD, IDX_CHG_INH_HOT, IDX_END_DSG_V,
    IDX_CHG_SUS_HOT, IDX_CHG_SUS_HOT_REC, IDX_DSG_HOT, IDX_DSG_HOT_REC, IDX_CHG_FATAL_HOT,
    IDX_DSG_FATAL_HOT, IDX_CHG_SUS_COLD, IDX_IGNORE_BAND, IDX_POWER_OFF_V, IDX_TEMP_CAL,
    IDX_COULOMB_CAL, IDX_CHG_SENSE, IDX_DSG_SENSE, IDX_LEAK_CHG, IDX_LEAK_DSG, IDX_LEAK_TIME,
    IDX_CONTROL};
  localparam logic [15:0] SLOT_MASK [NSLOT] = '{16'h00ff, 16'hffff, 16'hffff, 16'hffff,
    16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'h00ff, 16'h00ff, 16'hffff, 16'h00ff,
    16'h00ff, 16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'h00ff, 16'h0007};
  localparam logic [15:0] SLOT_RESET = 16'h0000;
  localparam int S_CINH_COLD = 0;
  localparam int S_CINH_HOT = 1;
  localparam int S_END_V = 2;
  localparam int S_CSUS_HOT = 3;
  localparam int S_CSUS_REC = 4;
  localparam int S_DHOT = 5;
  localparam int S_DHOT_REC = 6;
  localparam int S_CFATAL = 7;
  localparam int S_DFATAL = 8;
  localparam int S_CSUS_COLD = 9;
  localparam int S_BAND = 10;
  localparam int S_POFF_V = 11;
  localparam int S_TCAL = 12;
  localparam int S_CCAL = 13;
  localparam int S_CSENSE = 14;
  localparam int S_DSENSE = 15;
  localparam int S_LEAK_C = 16;
  localparam int S_LEAK_D = 17;
  localparam int S_LEAK_T = 18;
  localparam int S_CTRL = 19;
  // control bits
  localparam int CTRL_FIXED = 0;
  localparam int CTRL_CFATAL_EN = 1;
  localparam int CTRL_DFATAL_EN = 2;
  // status bits
  localparam int ST_COLD_SUS = 0;
  localparam int ST_HOT_SUS = 1;
  localparam int ST_DSG_HOT = 2;
  localparam int ST_PERM = 3;
  localparam int ST_CHG_ZERO = 4;
  localparam int ST_END_ALARM = 5;
  localparam int ST_LEAK_C = 6;
  localparam int ST_LEAK_D = 7;
  localparam int ST_SHUTDOWN = 8;
  localparam int ST_PRESENT = 9;
  localparam int ST_CHARGING = 10;
  localparam int ST_DISCHARGING = 11;
  localparam int ST_CHG_SW = 12;
  localparam int ST_DSG_SW = 13;
endpackage

/* File: rtl/ptcg_guard.sv */
// pack thermal/current guard: threshold supervision with a classic wishbone register slave
`timescale 1ns/1ps
module ptcg_guard #(
  parameter int TICKS_PER_SEC = ptcg_pkg::CYCLES_PER_SECOND
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ptcg_pkg::ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [ptcg_pkg::DATA_W-1:0] wb_dat_i,
  output logic [ptcg_pkg::DATA_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic meas_valid,
  input wire logic [15:0] temp_raw,
  input wire logic [15:0] current_raw,
  input wire logic [15:0] voltage_raw,
  input wire logic [15:0] coulomb_raw,
  input wire logic pack_present_pin,
  input wire logic adapter_present_pin,
  input wire logic cell_undervoltage_flag,
  output logic charge_switch,
  output logic discharge_switch,
  output logic pack_manager_status,
  output logic charge_request_zero,
  output logic end_discharge_alarm,
  output logic temp_failure,
  output logic perm_failure,
  output logic switch_failure,
  output logic shutdown_req,
  output logic [15:0] temp_calibrated,
  output logic [15:0] current_filtered,
  output logic [15:0] coulomb_calibrated
);
  import ptcg_pkg::*;

  // pin synchronisers
  logic [2:0] sync1_ff, sync2_ff;
  logic present, adapter, cuv;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sync1_ff <= 3'h0;
      sync2_ff <= 3'h0;
    end else begin
      sync1_ff <= {cell_undervoltage_flag, adapter_present_pin, pack_present_pin};
      sync2_ff <= sync1_ff;
    end
  end
  assign present = sync2_ff[0];
  assign adapter = sync2_ff[1];
  assign cuv = sync2_ff[2];

  // register file and wishbone slave
  logic [15:0] cfg_ff [NSLOT];
  logic [15:0] nxt_cfg [NSLOT];
  logic ack_ff, nxt_ack;
  logic [DATA_W-1:0] rdat_ff, nxt_rdat;
  logic [15:0] status;
  logic [8:0] idx;
  logic req;
  assign idx = wb_adr_i[10:2];
  assign req = wb_cyc_i && wb_stb_i && !ack_ff;

  always_comb begin
    nxt_ack = req;
    nxt_rdat = '0;
    for (int s = 0; s < NSLOT; s++) begin
      nxt_cfg[s] = cfg_ff[s];
      if (req && idx == SLOT_IDX[s] && wb_adr_i[ADDR_W-1] == 1'b0) begin
        if (wb_we_i) begin
          if (wb_sel_i[0]) nxt_cfg[s][7:0] = wb_dat_i[7:0] & SLOT_MASK[s][7:0];
          if (wb_sel_i[1]) nxt_cfg[s][15:8] = wb_dat_i[15:8] & SLOT_MASK[s][15:8];
        end else begin
          nxt_rdat = {16'h0000, cfg_ff[s]};
        end
      end
    end
    // status sits after the writable slots and ignores writes
    if (req && !wb_we_i && idx == IDX_STATUS && wb_adr_i[ADDR_W-1] == 1'b0) begin
      nxt_rdat = {16'h0000, status};
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ack_ff <= 1'b0;
      rdat_ff <= '0;
      for (int s = 0; s < NSLOT; s++) cfg_ff[s] <= SLOT_RESET;
    end else begin
      ack_ff <= nxt_ack;
      rdat_ff <= nxt_rdat;
      for (int s = 0; s < NSLOT; s++) cfg_ff[s] <= nxt_cfg[s];
    end
  end
  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;

  // sample arithmetic in 18-bit signed so the temperature offset never wraps; the coulomb offset is added in 16 bits and wraps
  logic signed [17:0] t_cal, i_raw, i_eff, v_s;
  logic [15:0] i_mag;
  logic signed [17:0] cold_sus_lim, cold_inh_lim;
  logic fixed_mode;
  assign fixed_mode = cfg_ff[S_CTRL][CTRL_FIXED]; // R19
  assign t_cal = 18'(signed'(temp_raw)) + 18'(signed'(cfg_ff[S_TCAL][7:0])); // R15
  assign i_raw = 18'(signed'(current_raw));
  assign i_mag = current_raw[15] ? 16'(-current_raw) : current_raw;
  assign i_eff = (i_mag < {8'h00, cfg_ff[S_BAND][7:0]}) ? 18'sh0_0000 : i_raw; // R17
  assign v_s = 18'({2'b00, voltage_raw});
  assign cold_sus_lim = 18'(signed'(cfg_ff[S_CSUS_COLD][7:0]));
  assign cold_inh_lim = 18'(signed'(cfg_ff[S_CINH_COLD][7:0]));

  function automatic logic signed [17:0] sx16(input logic [15:0] v);
    sx16 = 18'(signed'(v));
  endfunction

  logic charging, discharging;
  logic below_cold_sus, above_cold_sus, below_cold_inh, above_hot_inh;
  logic above_hot_sus, below_hot_rec, above_dsg_hot, below_dsg_rec;
  logic above_cfatal, above_dfatal, below_end_v, above_end_v, below_poff;
  assign charging = i_eff >= sx16(cfg_ff[S_CSENSE]); // R11
  assign discharging = i_eff <= sx16(cfg_ff[S_DSENSE]); // R12
  assign below_cold_sus = t_cal < cold_sus_lim;
  assign above_cold_sus = t_cal > cold_sus_lim;
  assign below_cold_inh = t_cal < cold_inh_lim;
  assign above_hot_inh = t_cal > sx16(cfg_ff[S_CINH_HOT]);
  assign above_hot_sus = t_cal > sx16(cfg_ff[S_CSUS_HOT]);
  assign below_hot_rec = t_cal < sx16(cfg_ff[S_CSUS_REC]);
  assign above_dsg_hot = t_cal > sx16(cfg_ff[S_DHOT]);
  assign below_dsg_rec = t_cal < sx16(cfg_ff[S_DHOT_REC]);
  assign above_cfatal = t_cal > sx16(cfg_ff[S_CFATAL]);
  assign above_dfatal = t_cal > sx16(cfg_ff[S_DFATAL]);
  assign below_end_v = v_s < 18'({2'b00, cfg_ff[S_END_V]});
  assign above_end_v = v_s > 18'({2'b00, cfg_ff[S_END_V]});
  assign below_poff = v_s < 18'({2'b00, cfg_ff[S_POFF_V]});

  // second prescaler drives the leak duration counters
  logic [31:0] pre_ff, nxt_pre;
  logic sec_tick;
  assign sec_tick = pre_ff == 32'(TICKS_PER_SEC - 1);
  always_comb nxt_pre = sec_tick ? 32'h0000_0000 : pre_ff + 32'h0000_0001;
  always_ff @(posedge clk) begin
    if (!rst_n) pre_ff <= 32'h0000_0000;
    else pre_ff <= nxt_pre;
  end

  // supervision state
  logic cold_sus_ff, hot_sus_ff, dsg_hot_ff, perm_ff, inh_ff, alarm_ff, shut_ff;
  logic chg_sw_ff, dsg_sw_ff, present_st_ff, chg_det_ff, dsg_det_ff;
  logic nxt_cold_sus, nxt_hot_sus, nxt_dsg_hot, nxt_perm, nxt_inh, nxt_alarm, nxt_shut;
  logic nxt_chg_sw, nxt_dsg_sw, nxt_present_st, nxt_chg_det, nxt_dsg_det;
  logic [1:0] leak_on_ff, nxt_leak_on, leak_fail_ff, nxt_leak_fail;
  logic [7:0] leak_cnt_ff [2];
  logic [7:0] nxt_leak_cnt [2];
  logic [15:0] t_out_ff, i_out_ff, cc_out_ff, nxt_t_out, nxt_i_out, nxt_cc_out;
  logic [1:0] leak_cond;
  logic block_chg;
  logic sw_fail_ff;

  // leak through an off switch in its own current direction
  assign leak_cond[0] = !chg_sw_ff && i_eff >= sx16(cfg_ff[S_LEAK_C]); // R13
  assign leak_cond[1] = !dsg_sw_ff && i_eff <= sx16(cfg_ff[S_LEAK_D]); // R13

  always_comb begin
    nxt_cold_sus = cold_sus_ff;
    nxt_hot_sus = hot_sus_ff;
    nxt_dsg_hot = dsg_hot_ff;
    nxt_perm = perm_ff;
    nxt_inh = inh_ff;
    nxt_alarm = alarm_ff;
    nxt_shut = shut_ff;
    nxt_chg_det = chg_det_ff;
    nxt_dsg_det = dsg_det_ff;
    nxt_leak_on = leak_on_ff;
    nxt_t_out = t_out_ff;
    nxt_i_out = i_out_ff;
    nxt_cc_out = cc_out_ff;
    block_chg = 1'b0;
    if (meas_valid) begin // R20
      nxt_t_out = t_cal[15:0];
      nxt_i_out = i_eff[15:0];
      nxt_cc_out = 16'(coulomb_raw + {{8{cfg_ff[S_CCAL][7]}}, cfg_ff[S_CCAL][7:0]}); // R16
      nxt_chg_det = charging;
      nxt_dsg_det = discharging;
      nxt_leak_on = leak_cond;
      // clears first, sets after, so a set in the same sample wins
      if (above_cold_sus || !present) nxt_cold_sus = 1'b0; // R2
      if (below_cold_sus) nxt_cold_sus = 1'b1; // R1
      if (below_hot_rec || !adapter || !present) nxt_hot_sus = 1'b0; // R6
      if (above_hot_sus && charging) nxt_hot_sus = 1'b1; // R5
      if (below_dsg_rec || (!present && !fixed_mode)) nxt_dsg_hot = 1'b0; // R8
      if (above_dsg_hot) nxt_dsg_hot = 1'b1; // R7
      if (charging && above_cfatal && cfg_ff[S_CTRL][CTRL_CFATAL_EN]) nxt_perm = 1'b1; // R9
      if (discharging && above_dfatal && cfg_ff[S_CTRL][CTRL_DFATAL_EN]) nxt_perm = 1'b1; // R10
      nxt_inh = below_cold_inh || above_hot_inh; // R3 R4
      if (above_end_v && !cuv) nxt_alarm = 1'b0; // R14
      if (below_end_v) nxt_alarm = 1'b1; // R14
      if (below_poff) nxt_shut = 1'b1; // R18
    end
    // switches move only on a sample, so they stay open after reset until a measurement arrives
    block_chg = nxt_cold_sus || nxt_hot_sus || nxt_dsg_hot || nxt_perm || nxt_shut
      || (nxt_inh && below_cold_inh); // R3
    nxt_chg_sw = meas_valid ? !block_chg : chg_sw_ff; // R1 R3 R7 R18
    nxt_dsg_sw = meas_valid ? !(nxt_dsg_hot || nxt_perm || nxt_shut) : dsg_sw_ff; // R7 R18
    nxt_present_st = nxt_cold_sus || nxt_hot_sus || nxt_dsg_hot; // R1 R5 R7
  end

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_leak
      always_comb begin
        nxt_leak_cnt[g] = leak_cnt_ff[g];
        nxt_leak_fail[g] = leak_fail_ff[g];
        if (meas_valid && !leak_cond[g]) begin
          nxt_leak_cnt[g] = 8'h00; // R13
        end else if (leak_on_ff[g] && sec_tick && leak_cnt_ff[g] != 8'hff) begin
          nxt_leak_cnt[g] = leak_cnt_ff[g] + 8'h01;
        end
        if (leak_on_ff[g] && leak_cnt_ff[g] >= cfg_ff[S_LEAK_T][7:0]
            && cfg_ff[S_LEAK_T][7:0] != 8'h00) begin
          nxt_leak_fail[g] = 1'b1; // R13
        end
      end
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          leak_cnt_ff[g] <= 8'h00;
          leak_fail_ff[g] <= 1'b0;
        end else begin
          leak_cnt_ff[g] <= nxt_leak_cnt[g];
          leak_fail_ff[g] <= nxt_leak_fail[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cold_sus_ff <= 1'b0;
      hot_sus_ff <= 1'b0;
      dsg_hot_ff <= 1'b0;
      perm_ff <= 1'b0;
      inh_ff <= 1'b0;
      alarm_ff <= 1'b0;
      shut_ff <= 1'b0;
      chg_sw_ff <= 1'b0;
      dsg_sw_ff <= 1'b0;
      present_st_ff <= 1'b0;
      chg_det_ff <= 1'b0;
      dsg_det_ff <= 1'b0;
      leak_on_ff <= 2'b00;
      sw_fail_ff <= 1'b0;
      t_out_ff <= 16'h0000;
      i_out_ff <= 16'h0000;
      cc_out_ff <= 16'h0000;
    end else begin
      cold_sus_ff <= nxt_cold_sus;
      hot_sus_ff <= nxt_hot_sus;
      dsg_hot_ff <= nxt_dsg_hot;
      perm_ff <= nxt_perm;
      inh_ff <= nxt_inh;
      alarm_ff <= nxt_alarm;
      shut_ff <= nxt_shut;
      chg_sw_ff <= nxt_chg_sw;
      dsg_sw_ff <= nxt_dsg_sw;
      present_st_ff <= nxt_present_st;
      chg_det_ff <= nxt_chg_det;
      dsg_det_ff <= nxt_dsg_det;
      leak_on_ff <= nxt_leak_on;
      sw_fail_ff <= |nxt_leak_fail; // R13
      t_out_ff <= nxt_t_out;
      i_out_ff <= nxt_i_out;
      cc_out_ff <= nxt_cc_out;
    end
  end

  assign status = {2'b00, dsg_sw_ff, chg_sw_ff, dsg_det_ff, chg_det_ff, present_st_ff, shut_ff,
    leak_fail_ff[1], leak_fail_ff[0], alarm_ff, inh_ff, perm_ff, dsg_hot_ff, hot_sus_ff, cold_sus_ff};
  assign charge_switch = chg_sw_ff;
  assign discharge_switch = dsg_sw_ff;
  assign pack_manager_status = present_st_ff;
  assign charge_request_zero = inh_ff;
  assign end_discharge_alarm = alarm_ff;
  // the present status flop already holds the or of the three temperature failures
  assign temp_failure = present_st_ff;
  assign perm_failure = perm_ff;
  assign switch_failure = sw_fail_ff;
  assign shutdown_req = shut_ff;
  assign temp_calibrated = t_out_ff;
  assign current_filtered = i_out_ff;
  assign coulomb_calibrated = cc_out_ff;

  // checks
  sequence wb_req_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence wb_ans_s;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  wb_ack_one_a: assert property (@(posedge clk) disable iff (!rst_n) wb_req_s |=> wb_ans_s) // R20
    else $error("wishbone ack not a single pulse after request");
  cold_suspend_a: assert property (@(posedge clk) disable iff (!rst_n) // R1
    meas_valid && below_cold_sus |=> cold_sus_ff && !charge_switch && pack_manager_status)
    else $error("cold suspend not entered");
  cold_clear_a: assert property (@(posedge clk) disable iff (!rst_n) // R2
    meas_valid && !present && !below_cold_sus |=> !cold_sus_ff)
    else $error("cold suspend not cleared on removal");
  hot_suspend_a: assert property (@(posedge clk) disable iff (!rst_n) // R5
    meas_valid && charging && above_hot_sus |=> hot_sus_ff && pack_manager_status && !charge_switch)
    else $error("hot suspend not entered while charging");
  inhibit_zero_a: assert property (@(posedge clk) disable iff (!rst_n) // R4
    meas_valid && (above_hot_inh || below_cold_inh) |=> charge_request_zero)
    else $error("charge request not zeroed");
  dsg_overheat_a: assert property (@(posedge clk) disable iff (!rst_n) // R7
    meas_valid && above_dsg_hot |=> !charge_switch && !discharge_switch && pack_manager_status)
    else $error("discharge overheat did not open both switches");
  perm_sticky_a: assert property (@(posedge clk) disable iff (!rst_n) // R9
    perm_failure |=> perm_failure [*3])
    else $error("permanent failure released");
  shutdown_off_a: assert property (@(posedge clk) disable iff (!rst_n) // R18
    meas_valid && below_poff |=> shutdown_req && !charge_switch && !discharge_switch)
    else $error("shutdown did not open switches");
  alarm_hold_a: assert property (@(posedge clk) disable iff (!rst_n) // R14
    end_discharge_alarm && cuv |=> end_discharge_alarm)
    else $error("alarm cleared while undervoltage flag set");
  leak_time_a: assert property (@(posedge clk) disable iff (!rst_n) // R13
    $rose(leak_fail_ff[0]) |-> $past(leak_cnt_ff[0]) >= cfg_ff[S_LEAK_T][7:0])
    else $error("switch failure before leak time elapsed");
endmodule
